// ===== logic/pbcs_pkg.sv
// Purpose: Constants for the basic control and status management registers
// Assumes: Clause-22 style serial management frames, 50 MHz system clock
// Notes:   Every offset, reset value and count lives here, with control and status field positions; frame field slices are literals in pbcs_regs
package pbcs_pkg;

    // ****************************************************************
    // Register offsets and whole-word reset values
    // ****************************************************************
    localparam logic [4:0]  REG_CONTROL    = 5'h00;
    localparam logic [4:0]  REG_STATUS     = 5'h01;
    localparam logic [15:0] CONTROL_RESET  = 16'h0140;
    localparam logic [15:0] STATUS_RESET   = 16'h0141;

    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int SOFT_RESET_BIT = 15;
    localparam int LOOPBACK_BIT   = 14;
    localparam int SPEED_LSB_BIT  = 13;
    localparam int POWER_DOWN_BIT = 11;
    localparam int ISOLATE_BIT    = 10;
    localparam int DUPLEX_BIT     = 8;
    localparam int SPEED_MSB_BIT  = 6;
    // Bits that never change, whatever software writes
    localparam logic [15:0] CONTROL_FIXED_MASK = 16'h2140;

    // ****************************************************************
    // Status field positions
    // ****************************************************************
    localparam logic [15:0] STATUS_LEGACY_MASK = 16'hFE00;
    localparam int          EXT_STATUS_BIT     = 8;
    localparam int          PREAMBLE_SUPP_BIT  = 6;

    // ****************************************************************
    // Management frame layout
    // ****************************************************************
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [4:0] HDR_LAST  = 5'h0B;
    localparam logic [4:0] DATA_LAST = 5'h0F;

    // ****************************************************************
    // Soft reset hold time
    // ****************************************************************
    localparam int CLK_PERIOD_NS     = 20;
    localparam int SOFT_RESET_NS     = 1000;
    localparam int SOFT_RESET_CYCLES =
        (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] SOFT_RESET_COUNT = 6'(SOFT_RESET_CYCLES);

    // Frame receiver states
    typedef enum logic [2:0] {
        PBCS_IDLE,
        PBCS_START,
        PBCS_HEADER,
        PBCS_TURN,
        PBCS_DATA
    } pbcs_state_t;

endpackage

// ===== logic/pbcs_regs.sv
// Purpose: Basic control and status registers behind the management pins
// Assumes: mdc_in and mdio_in are synchronous to sys_clk_in
// Notes:   Preamble is optional; idle ones before the start bits are skipped
`timescale 1ns/10ps

// Notes on behaviour
// - Writing control bit 15 resets digital logic and registers; reads zero idle.
// - Bit 11 powers down (register or pin); bit 10 isolates; both reset zero.
// - Status bit 8 always reads one: extended status present.
// - Status bit 6 always one; frames without preamble are accepted.
// - Status bits 15 to 9 legacy abilities always read zero.
// - Control resets to 0x140, status reads 0x141.
module pbcs_regs
    import pbcs_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       mdc_in,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe_out,
    input  wire logic [4:0] phy_addr_in,
    input  wire logic       power_down_pin_in,
    output logic            loopback_out,
    output logic            power_down_out,
    output logic            isolate_out,
    output logic            digital_reset_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    pbcs_state_t state_reg;
    logic        mdc_prev_reg;
    logic [4:0]  bit_cnt_reg;
    logic [11:0] hdr_reg;
    logic [15:0] shift_reg;
    logic [5:0]  soft_cnt_reg;
    logic        loopback_reg;
    logic        power_down_reg;
    logic        isolate_reg;

    logic        mdc_rise_w;
    logic        addr_hit_w;
    logic        is_read_w;
    logic        rd_hit_w;
    logic        soft_active_w;
    logic        wr_fire_w;
    logic [15:0] wdata_w;
    logic [15:0] ctrl_word_w;

    // Read value for a register offset
    function automatic logic [15:0] read_word(input logic [4:0] addr,
                                              input logic [15:0] ctrl);
        logic [15:0] val;
        val = 16'h0000;
        if (addr == REG_CONTROL) begin
            val = ctrl;
        end else if (addr == REG_STATUS) begin
            val = STATUS_RESET;
        end
        return val;
    endfunction

    // ****************************************************************
    // Decode
    // ****************************************************************
    // Frame fields and strobes
    assign mdc_rise_w    = mdc_in & ~mdc_prev_reg;
    assign addr_hit_w    = (hdr_reg[9:5] == phy_addr_in);
    assign is_read_w     = (hdr_reg[11:10] == OP_READ);
    assign rd_hit_w      = addr_hit_w & is_read_w;
    assign soft_active_w = (soft_cnt_reg != 6'h00);
    assign wdata_w       = {shift_reg[14:0], mdio_in};
    assign wr_fire_w     = mdc_rise_w && (state_reg == PBCS_DATA)
                           && (bit_cnt_reg == DATA_LAST) && addr_hit_w
                           && (hdr_reg[11:10] == OP_WRITE)
                           && (hdr_reg[4:0] == REG_CONTROL);
    // default word, speed and duplex fixed
    assign ctrl_word_w   = CONTROL_RESET | {soft_active_w, loopback_reg,
                           2'h0, power_down_reg, isolate_reg, 10'h000};

    // ****************************************************************
    // Management frame receiver
    // ****************************************************************
    // Edge detect of the management clock
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mdc_prev_reg <= 1'b0;
        end else begin
            mdc_prev_reg <= mdc_in;
        end
    end

    // Frame sequencing, shifting and pin drive
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg   <= PBCS_IDLE;
            bit_cnt_reg <= 5'h00;
            hdr_reg     <= 12'h000;
            shift_reg   <= 16'h0000;
            mdio_out    <= 1'b0;
            mdio_oe_out <= 1'b0;
        end else if (mdc_rise_w) begin
            unique case (state_reg)
                PBCS_IDLE: begin
                    // a zero with or without preamble opens a frame
                    if (!mdio_in) begin
                        state_reg <= PBCS_START;
                    end
                end
                PBCS_START: begin
                    state_reg   <= mdio_in ? PBCS_HEADER : PBCS_IDLE;
                    bit_cnt_reg <= 5'h00;
                end
                PBCS_HEADER: begin
                    hdr_reg     <= {hdr_reg[10:0], mdio_in};
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == HDR_LAST) begin
                        state_reg   <= PBCS_TURN;
                        bit_cnt_reg <= 5'h00;
                    end
                end
                PBCS_TURN: begin
                    if (bit_cnt_reg == 5'h00) begin
                        bit_cnt_reg <= 5'h01;
                        shift_reg   <= read_word(hdr_reg[4:0], ctrl_word_w);
                        mdio_oe_out <= rd_hit_w;
                        mdio_out    <= 1'b0;
                    end else begin
                        state_reg   <= PBCS_DATA;
                        bit_cnt_reg <= 5'h00;
                        if (rd_hit_w) begin
                            mdio_out  <= shift_reg[15];
                            shift_reg <= {shift_reg[14:0], 1'b0};
                        end
                    end
                end
                PBCS_DATA: begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (rd_hit_w) begin
                        mdio_out  <= shift_reg[15];
                        shift_reg <= {shift_reg[14:0], 1'b0};
                    end else begin
                        shift_reg <= wdata_w;
                    end
                    if (bit_cnt_reg == DATA_LAST) begin
                        state_reg   <= PBCS_IDLE;
                        mdio_oe_out <= 1'b0;
                        mdio_out    <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    // soft reset clears fields and holds for a fixed time
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            soft_cnt_reg   <= 6'h00;
            loopback_reg   <= 1'b0;
            power_down_reg <= 1'b0;
            isolate_reg    <= 1'b0;
        end else if (wr_fire_w && wdata_w[SOFT_RESET_BIT]) begin
            soft_cnt_reg   <= SOFT_RESET_COUNT;
            loopback_reg   <= 1'b0;
            power_down_reg <= 1'b0;
            isolate_reg    <= 1'b0;
        end else if (soft_active_w) begin
            soft_cnt_reg   <= soft_cnt_reg - 6'h01;
        end else if (wr_fire_w) begin
            loopback_reg   <= wdata_w[LOOPBACK_BIT];
            power_down_reg <= wdata_w[POWER_DOWN_BIT];
            isolate_reg    <= wdata_w[ISOLATE_BIT];
        end
    end

    // registered mode outputs, power down also from the pin
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            loopback_out      <= 1'b0;
            power_down_out    <= 1'b0;
            isolate_out       <= 1'b0;
            digital_reset_out <= 1'b0;
        end else begin
            loopback_out      <= loopback_reg;
            power_down_out    <= power_down_reg | power_down_pin_in;
            isolate_out       <= isolate_reg;
            digital_reset_out <= soft_active_w;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    // Cycles between the first and the last high sample of the hold
    localparam int SR_MID = SOFT_RESET_CYCLES - 1;

    sequence s_soft_write;
        wr_fire_w && wdata_w[SOFT_RESET_BIT];
    endsequence

    sequence s_plain_write;
        wr_fire_w && !wdata_w[SOFT_RESET_BIT] && !soft_active_w;
    endsequence

    a_soft_reset_hold: assert property (
        s_soft_write |-> ##2 digital_reset_out ##SR_MID digital_reset_out
            ##1 !digital_reset_out)
        else $error("soft reset not held for its time");

    a_soft_reset_clear: assert property (
        s_soft_write |=> !loopback_reg && !power_down_reg && !isolate_reg)
        else $error("soft reset left control fields set");

    a_loopback_write: assert property (
        s_plain_write |-> ##2 (loopback_out == $past(wdata_w[LOOPBACK_BIT], 2)))
        else $error("loopback output does not follow write");

    a_power_down_path: assert property (
        (power_down_reg || power_down_pin_in) |=> power_down_out)
        else $error("power down not asserted");

    a_isolate_write: assert property (
        s_plain_write |-> ##2 (isolate_out == $past(wdata_w[ISOLATE_BIT], 2)))
        else $error("isolate output does not follow write");

    a_status_read_word: assert property (
        mdc_rise_w && state_reg == PBCS_TURN && bit_cnt_reg == 5'h00
        && hdr_reg[4:0] == REG_STATUS |=> shift_reg[EXT_STATUS_BIT]
        && shift_reg[PREAMBLE_SUPP_BIT] && shift_reg[0]
        && (shift_reg & STATUS_LEGACY_MASK) == 16'h0000)
        else $error("status word wrong at read");

    a_no_preamble_start: assert property (
        mdc_rise_w && state_reg == PBCS_IDLE && !mdio_in
        |=> state_reg == PBCS_START)
        else $error("frame start without preamble refused");

    a_read_turnaround: assert property (
        mdc_rise_w && state_reg == PBCS_TURN && bit_cnt_reg == 5'h00
        && rd_hit_w |=> mdio_oe_out && !mdio_out)
        else $error("turnaround zero not driven on read");

    a_reset_word: assert property (
        $fell(soft_active_w) |-> ctrl_word_w == CONTROL_RESET)
        else $error("control word not default after soft reset");

    a_fixed_bits: assert property (
        wr_fire_w |=> (ctrl_word_w & CONTROL_FIXED_MASK)
        == (CONTROL_RESET & CONTROL_FIXED_MASK))
        else $error("fixed speed or duplex bits changed");

endmodule

// ===== tb/pbcs_mgmt_model.sv
// Purpose: Station management controller model for the register block
// Assumes: Shared data line has a pull-up; 3 sys clocks per clock phase
// Notes:   Management clock stands low between frames
`timescale 1ns/10ps
module pbcs_mgmt_model
    import pbcs_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic mdio_line_in,
    output logic      mdc_out,
    output logic      mdio_out,
    output logic      mdio_oe_out
);
    // ****************************************************************
    // Bit and frame tasks
    // ****************************************************************
    initial begin
        mdc_out     = 1'b0;
        mdio_out    = 1'b1;
        mdio_oe_out = 1'b0;
    end

    // Drive in the low phase, sample just before the rise
    task automatic bit_cycle(input logic b, input logic drv, output logic s);
        @(posedge sys_clk_in);
        mdc_out     <= 1'b0;
        mdio_out    <= b;
        mdio_oe_out <= drv;
        repeat (2) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        s = mdio_line_in;
        @(posedge sys_clk_in);
        mdc_out <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
    endtask

    // Whole frame; a read releases the line from turnaround onwards
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] ra, input logic [15:0] wd,
                        input int pre, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        s;
        logic        drv;
        hdr = {2'b01, op, phy, ra};
        drv = (op == OP_WRITE);
        rd  = 16'h0000;
        for (int i = 0; i < pre; i++) begin
            bit_cycle(1'b1, 1'b1, s);
        end
        for (int i = 13; i >= 0; i--) begin
            bit_cycle(hdr[i], 1'b1, s);
        end
        bit_cycle(1'b1, drv, s);
        bit_cycle(1'b0, drv, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(wd[i], drv, s);
            rd[i] = s;
        end
        @(posedge sys_clk_in);
        mdc_out     <= 1'b0;
        mdio_oe_out <= 1'b0;
    endtask
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the basic control and status registers
// Assumes: Management model on the far side, pull-up on the data line
// Notes:   Default words are built from the package constants; the others are literals
`timescale 1ns/10ps
module testbench;
    import pbcs_pkg::*;
    localparam logic [4:0] MY_PHY = 5'h0B;
    logic sys_clk_in, rstn_in, pin_pd, m_mdc, m_out, m_oe;
    logic d_out, d_oe, lb, pd, iso, drst;
    wire  logic mdio_line;
    int   bad_count, n_tests, k, n;
    int   drst_cycles, drst_base;

    // Line level: device, then model, else pulled up
    assign mdio_line = d_oe ? d_out : (m_oe ? m_out : 1'b1);

    pbcs_regs u_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .mdc_in(m_mdc), .mdio_in(mdio_line), .mdio_out(d_out),
        .mdio_oe_out(d_oe), .phy_addr_in(MY_PHY),
        .power_down_pin_in(pin_pd), .loopback_out(lb),
        .power_down_out(pd), .isolate_out(iso), .digital_reset_out(drst));
    pbcs_mgmt_model u_mgmt (.sys_clk_in(sys_clk_in),
        .mdio_line_in(mdio_line), .mdc_out(m_mdc), .mdio_out(m_out),
        .mdio_oe_out(m_oe));

    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    // Cycles spent in soft reset, counted at the falling edge
    always @(negedge sys_clk_in) begin
        if (drst === 1'b1) begin
            drst_cycles <= drst_cycles + 1;
        end
    end

    // ****************************************************************
    // Compare, access and closing tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] phy, input logic [4:0] ra,
                          input int pre, input logic [15:0] exp);
        logic [15:0] d;
        u_mgmt.xfer(OP_READ, phy, ra, 16'h0000, pre, d);
        check(d, exp);
    endtask
    task automatic wr(input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd);
        logic [15:0] d;
        u_mgmt.xfer(OP_WRITE, phy, ra, wd, 0, d);
        repeat (3) @(posedge sys_clk_in);
    endtask
    task automatic modes(input logic [3:0] exp);
        check({12'h000, lb, pd, iso, drst}, {12'h000, exp});
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        bad_count = 0;
        n_tests   = 0;
        rstn_in   = 1'b0;
        pin_pd    = 1'b0;
        repeat (6) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        modes(4'h0);
        rd_chk(MY_PHY, REG_CONTROL, 32, CONTROL_RESET);
        rd_chk(MY_PHY, REG_STATUS, 0, STATUS_RESET);
        wr(MY_PHY, REG_CONTROL, 16'h7FFF);
        modes(4'hE);
        rd_chk(MY_PHY, REG_CONTROL, 0, 16'h4D40);
        wr(MY_PHY, REG_STATUS, 16'h0000);
        rd_chk(MY_PHY, REG_STATUS, 0, STATUS_RESET);
        rd_chk(MY_PHY, 5'h02, 0, 16'h0000);
        // Other address: no write, line left to the pull-up
        wr(MY_PHY ^ 5'h01, REG_CONTROL, 16'h0000);
        rd_chk(MY_PHY ^ 5'h01, REG_CONTROL, 0, 16'hFFFF);
        modes(4'hE);
        wr(MY_PHY, REG_CONTROL, 16'h0800);
        modes(4'h4);
        rd_chk(MY_PHY, REG_CONTROL, 0, 16'h0940);
        wr(MY_PHY, REG_CONTROL, 16'h0000);
        pin_pd <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        modes(4'h4);
        rd_chk(MY_PHY, REG_CONTROL, 0, CONTROL_RESET);
        pin_pd <= 1'b0;
        wr(MY_PHY, REG_CONTROL, 16'h4400);
        modes(4'hA);
        // Soft reset: hold length, then defaults
        drst_base = drst_cycles;
        wr(MY_PHY, REG_CONTROL, 16'h8000);
        k = 0;
        while (drst !== 1'b1 && k < 10) begin
            @(negedge sys_clk_in);
            k++;
        end
        n = 0;
        while (drst === 1'b1 && n < 200) begin
            @(negedge sys_clk_in);
            n++;
        end
        if (n >= 200) begin
            bad_count++;
        end
        check(16'(drst_cycles - drst_base), 16'(SOFT_RESET_CYCLES));
        modes(4'h0);
        rd_chk(MY_PHY, REG_CONTROL, 0, CONTROL_RESET);
        // Second device reset in mid-run
        wr(MY_PHY, REG_CONTROL, 16'h0400);
        modes(4'h2);
        rstn_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        modes(4'h0);
        rd_chk(MY_PHY, REG_CONTROL, 0, CONTROL_RESET);
        test_done();
    end
endmodule
